// ---- logic/spe_params.svh ----
`ifndef SPE_PARAMS_SVH
`define SPE_PARAMS_SVH

// ****************************************************************
// clock and serial timing
// ****************************************************************
`define SPE_CLK_PERIOD_NS   4
`define SPE_CLK_MHZ         250
`define SPE_HALF_BIT_NS     1000
`define SPE_HALF_BIT_CYC    (`SPE_HALF_BIT_NS / `SPE_CLK_PERIOD_NS)
`define SPE_READ_CYCLE_US   200
`define SPE_WRITE_CYCLE_US  100
`define SPE_PROG_TIMEOUT_MS 20

// ****************************************************************
// frame layout
// ****************************************************************
`define SPE_CMD_BITS        9
`define SPE_FRAME_BITS      25
`define SPE_LAST_CMD_BIT    5'h08
`define SPE_LAST_FRAME_BIT  5'h18
`define SPE_FIRST_DATA_BIT  5'h09

// ****************************************************************
// commands: start bit, opcode, address
// ****************************************************************
`define SPE_CMD_READ_W0     9'h180
`define SPE_CMD_READ_W1     9'h181
`define SPE_CMD_EWEN        9'h130
`define SPE_CMD_WRITE_W0    9'h140

// ****************************************************************
// word 0 contents
// ****************************************************************
`define SPE_WORD0_PAD       8'h00
`define SPE_ADDR_ZERO       7'h00
`define SPE_ADDR_MAX        7'h7F
`define SPE_ADDR_DEFAULT    7'h7E

`endif

// ---- logic/spe_pkg.sv ----
package spe_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_SHIFT = 3'b001,
    ST_GAP   = 3'b011,
    ST_READY = 3'b010,
    ST_PAD   = 3'b110,
    ST_DONE  = 3'b111
  } spe_state_e;

  typedef struct packed
  {
    logic        lock;
    logic [6:0]  addr;
  } spe_addr_s;

  typedef struct packed
  {
    logic        lock;
    logic [6:0]  addr;
    logic [15:0] id;
  } spe_param_s;

endpackage

// ---- logic/spe_ctrl.sv ----
// How it works
// - serial-parameter enable and memory-type select both high route station parameters through the serial memory path.
// - read words 0 and 1 only; write only word 0.
// - after every reset in memory mode, fetch word 0 and word 1 into the parameter register.
// - address 0 or 127 read in triggers write-back of 126, lock cleared.
// - the ID word is never written; memory must hold it beforehand.
// - a write-enable command precedes every write command.
// - sequencer sets read or write flag; controller clears it on completion.
// - select, clock and data-out are low after reset in memory mode.
// - serial input carries read data and ready; sampled through a buffer.
// - read data shifts into an internal register, then read flag clears.
// - new address loads only from an error-free telegram; sequencer continues.
// - a write request is acknowledged, then baud-rate detection is requested.
// - a write request without memory attached answers with negative acknowledge.
// - each command is start bit 1, 2-bit opcode, 6-bit address.
// - read 110 addr 0/1, enable 100 addr 110000, write 101 addr 0.
// - no erase command is ever sent.
// - controller makes clock and select, shifts commands out, data in.
// - a full read cycle takes 200 microseconds.
// - a write takes at least 100 microseconds from its start, longer only if programming keeps ready low past that.
// - address-change-allowed high permits overwrite despite the lock flag.
`timescale 1ns/10ps
`include "spe_params.svh"

module spe_ctrl
  import spe_pkg::*;
#(
  parameter int unsigned READ_CYCLE_CYC   = `SPE_READ_CYCLE_US * `SPE_CLK_MHZ,
  parameter int unsigned WRITE_CYCLE_CYC  = `SPE_WRITE_CYCLE_US * `SPE_CLK_MHZ,
  parameter int unsigned PROG_TIMEOUT_CYC = `SPE_PROG_TIMEOUT_MS * 1000 * `SPE_CLK_MHZ
)
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // configuration pins
  input  wire logic       serial_param_enable,
  input  wire logic       eeprom_or_shifter_select,
  input  wire logic       address_change_allowed,
  // control sequencer requests
  input  wire logic       read_req_set,
  input  wire logic       write_req_set,
  input  wire logic       telegram_ok,
  input  spe_addr_s       new_address,
  // control sequencer status
  output logic            read_req,
  output logic            write_req,
  output logic            write_accept,
  output logic            write_nack_rs,
  output logic            baud_detect_req,
  output logic            params_valid,
  output spe_param_s      params,
  // serial memory pins
  output logic            param_mem_select,
  output logic            param_mem_serial_clock,
  output logic            param_mem_serial_out,
  input  wire logic       param_mem_serial_in
);

  // ****************************************************************
  // decoding
  // ****************************************************************
  function automatic logic is_bad_addr(input logic [6:0] a);
    is_bad_addr = (a == `SPE_ADDR_ZERO) || (a == `SPE_ADDR_MAX);
  endfunction

  // only read, enable and write-word-0 exist here; no erase, no ID write
  function automatic logic [24:0] frame(input logic wr, input logic st, input spe_addr_s d);
    if (!wr)
      frame = {(st ? `SPE_CMD_READ_W1 : `SPE_CMD_READ_W0), 16'h0000};
    else if (!st)
      frame = {`SPE_CMD_EWEN, 16'h0000};
    else
      frame = {`SPE_CMD_WRITE_W0, `SPE_WORD0_PAD, d};
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0]  pin_raw;
  logic [3:0]  pin_s1;
  logic [3:0]  pin_s2;
  logic        eeprom_mode;
  logic        aca_s;
  logic        di_s;

  assign pin_raw = {param_mem_serial_in, address_change_allowed,
                    eeprom_or_shifter_select, serial_param_enable};

  // the analog hysteresis lives in the pad; here only metastability is handled
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  assign eeprom_mode = pin_s2[0] & pin_s2[1];
  assign aca_s       = pin_s2[2];
  assign di_s        = pin_s2[3];

  // ****************************************************************
  // boot fetch trigger
  // ****************************************************************
  logic [1:0]  boot_cnt;
  logic        boot_fire;

  // wait for the straps to settle through the synchroniser before reading them
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      boot_cnt <= 2'h0;
    else if (boot_cnt != 2'h3)
      boot_cnt <= boot_cnt + 2'h1;
  end

  assign boot_fire = (boot_cnt == 2'h2);

  // ****************************************************************
  // state, divider and cycle counter
  // ****************************************************************
  spe_state_e  state;
  logic [7:0]  tick_cnt;
  logic        tick;
  logic [23:0] cyc_cnt;
  logic        done;

  assign tick = (tick_cnt == 8'(`SPE_HALF_BIT_CYC - 1));
  assign done = (state == ST_DONE);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      tick_cnt <= 8'h00;
    else if (state == ST_IDLE || tick)
      tick_cnt <= 8'h00;
    else
      tick_cnt <= tick_cnt + 8'h01;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cyc_cnt <= 24'h000000;
    else if (state == ST_IDLE)
      cyc_cnt <= 24'h000000;
    else
      cyc_cnt <= cyc_cnt + 24'h000001;
  end

  // ****************************************************************
  // request flags
  // ****************************************************************
  spe_addr_s   wr_data;
  logic        job_wr;
  logic        addr_written;
  logic        wr_ok;
  logic        auto_default;

  // after power-on the address may always be overwritten once
  assign wr_ok = eeprom_mode && telegram_ok && !write_req &&
                 (!params.lock || aca_s || !addr_written);
  assign auto_default = done && !job_wr && is_bad_addr(params.addr);

  // set wins over clear for the read flag; a write set is refused while write_req is high
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      read_req <= 1'b0;
    else if (eeprom_mode && (boot_fire || read_req_set))
      read_req <= 1'b1;
    else if (done && !job_wr)
      read_req <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      write_req <= 1'b0;
      wr_data   <= '0;
    end
    else if (auto_default)
    begin
      write_req <= 1'b1;
      wr_data   <= '{lock: 1'b0, addr: `SPE_ADDR_DEFAULT};
    end
    else if (write_req_set && wr_ok)
    begin
      write_req <= 1'b1;
      wr_data   <= new_address;
    end
    else if (done && job_wr)
      write_req <= 1'b0;
  end

  // ****************************************************************
  // sequencer answers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      write_accept    <= 1'b0;
      baud_detect_req <= 1'b0;
      write_nack_rs   <= 1'b0;
    end
    else
    begin
      write_accept    <= write_req_set && wr_ok;
      baud_detect_req <= write_accept;
      write_nack_rs   <= write_req_set && !eeprom_mode;
    end
  end

  // ****************************************************************
  // serial engine
  // ****************************************************************
  logic        step;
  logic        ewen_seen;
  logic [24:0] shreg;
  logic [4:0]  bit_idx;
  logic [4:0]  last_idx;
  logic [15:0] rx;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state                  <= ST_IDLE;
      job_wr                 <= 1'b0;
      step                   <= 1'b0;
      shreg                  <= '0;
      bit_idx                <= 5'h00;
      last_idx               <= 5'h00;
      rx                     <= 16'h0000;
      param_mem_select       <= 1'b0;
      param_mem_serial_clock <= 1'b0;
      param_mem_serial_out   <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          param_mem_select       <= 1'b0;
          param_mem_serial_clock <= 1'b0;
          param_mem_serial_out   <= 1'b0;
          // a pending read goes first so a fresh boot image is never overwritten
          if (eeprom_mode && (read_req || write_req))
          begin
            job_wr               <= !read_req;
            step                 <= 1'b0;
            shreg                <= frame(!read_req, 1'b0, wr_data);
            param_mem_serial_out <= 1'b1;
            param_mem_select     <= 1'b1;
            bit_idx              <= 5'h00;
            last_idx             <= read_req ? `SPE_LAST_FRAME_BIT : `SPE_LAST_CMD_BIT;
            state                <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (tick && !param_mem_serial_clock)
            param_mem_serial_clock <= 1'b1;
          else if (tick)
          begin
            param_mem_serial_clock <= 1'b0;
            if (!job_wr && bit_idx >= `SPE_FIRST_DATA_BIT)
              rx <= {rx[14:0], di_s};
            if (bit_idx == last_idx)
            begin
              param_mem_select     <= 1'b0;
              param_mem_serial_out <= 1'b0;
              state                <= ST_GAP;
            end
            else
            begin
              bit_idx              <= bit_idx + 5'h01;
              shreg                <= {shreg[23:0], 1'b0};
              param_mem_serial_out <= shreg[23];
            end
          end
        end
        ST_GAP:
        begin
          if (tick && !step)
          begin
            step                 <= 1'b1;
            shreg                <= frame(job_wr, 1'b1, wr_data);
            param_mem_serial_out <= 1'b1;
            param_mem_select     <= 1'b1;
            bit_idx              <= 5'h00;
            last_idx             <= `SPE_LAST_FRAME_BIT;
            state                <= ST_SHIFT;
          end
          else if (tick && job_wr)
          begin
            param_mem_select <= 1'b1;
            state            <= ST_READY;
          end
          else if (tick)
            state <= ST_PAD;
        end
        ST_READY:
        begin
          // a dead memory must not hang the write flag forever
          if (tick && (di_s || cyc_cnt >= 24'(PROG_TIMEOUT_CYC)))
          begin
            param_mem_select <= 1'b0;
            state            <= ST_PAD;
          end
        end
        ST_PAD:
        begin
          if (cyc_cnt >= (job_wr ? 24'(WRITE_CYCLE_CYC) : 24'(READ_CYCLE_CYC)))
            state <= ST_DONE;
        end
        ST_DONE:
          state <= ST_IDLE;
        default:
        begin
          param_mem_select       <= 1'b0;
          param_mem_serial_clock <= 1'b0;
          param_mem_serial_out   <= 1'b0;
          state                  <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // parameter register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      params       <= '0;
      params_valid <= 1'b0;
      addr_written <= 1'b0;
      ewen_seen    <= 1'b0;
    end
    else
    begin
      if (state == ST_GAP && tick && !job_wr && !step)
        {params.lock, params.addr} <= rx[7:0];
      if (state == ST_GAP && tick && !job_wr && step)
        params.id <= rx;
      if (state == ST_GAP && tick && job_wr && !step)
        ewen_seen <= 1'b1;
      else if (done)
        ewen_seen <= 1'b0;
      if (done && !job_wr)
        params_valid <= 1'b1;
      if (done && job_wr)
      begin
        addr_written <= 1'b1;
        params.lock  <= wr_data.lock;
        params.addr  <= wr_data.addr;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_idle_pins_low: assert property (
    state == ST_IDLE && $past(state) == ST_IDLE |->
      !param_mem_select && !param_mem_serial_clock && !param_mem_serial_out)
    else $error("memory pins not low while idle");
  chk_clock_in_select: assert property (
    param_mem_serial_clock |-> param_mem_select)
    else $error("serial clock toggles outside select");
  chk_start_bit_high: assert property (
    $rose(param_mem_select) && state == ST_SHIFT |-> param_mem_serial_out && bit_idx == 5'h00)
    else $error("command did not open with start bit");
  chk_write_word_zero: assert property (
    $rose(param_mem_select) && state == ST_SHIFT && job_wr && step |->
      shreg[24:16] == `SPE_CMD_WRITE_W0 && shreg[15:8] == `SPE_WORD0_PAD)
    else $error("write aimed at a word other than 0");
  chk_enable_before_write: assert property (
    $rose(param_mem_select) && state == ST_SHIFT && job_wr && step |-> ewen_seen)
    else $error("write without prior write enable");
  chk_read_flag_clear: assert property (
    $fell(read_req) |-> $past(state) == ST_DONE && !$past(job_wr))
    else $error("read flag cleared outside completion");
  chk_read_length: assert property (
    $fell(read_req) |-> $past(cyc_cnt) >= 24'(READ_CYCLE_CYC))
    else $error("read cycle too short");
  chk_write_length: assert property (
    $fell(write_req) |-> $past(cyc_cnt) >= 24'(WRITE_CYCLE_CYC))
    else $error("write cycle too short");
  chk_default_address: assert property (
    auto_default |=> write_req && wr_data.addr == `SPE_ADDR_DEFAULT && !wr_data.lock)
    else $error("illegal address not replaced by default");
  chk_nack_no_memory: assert property (
    write_req_set && !eeprom_mode |=>
      write_nack_rs ##1 (!write_nack_rs || $past(write_req_set && !eeprom_mode)))
    else $error("missing negative acknowledge");
  chk_ack_then_baud: assert property (
    write_accept |=> baud_detect_req)
    else $error("baud detection not requested after ack");

  cov_read_done:    cover property ($fell(read_req));
  cov_write_done:   cover property ($fell(write_req));
  cov_auto_default: cover property (auto_default);
  cov_nack:         cover property (write_nack_rs);

endmodule

// ---- bench/spe_eeprom_model.sv ----
`timescale 1ns/10ps
`include "spe_params.svh"

// ****************************************************************
// serial 16-bit parameter memory, behavioural
// ****************************************************************
module spe_eeprom_model #(
  parameter int PROG_NS = 3000
)
(
  // memory pins
  input  wire logic param_mem_select,
  input  wire logic param_mem_serial_clock,
  input  wire logic param_mem_serial_out,
  output logic      param_mem_serial_in
);
  logic [15:0] mem [0:1];
  logic [8:0]  cmd;
  logic [15:0] data;
  logic        ewen;
  logic        busy;
  int          cnt;
  int          n_write;
  int          n_bad;

  initial
  begin
    param_mem_serial_in = 1'b0;
    ewen = 1'b0;
    busy = 1'b0;
    n_write = 0;
    n_bad = 0;
  end

  // status shows on the data line only while selected
  always @(posedge param_mem_select)
  begin
    cnt = 0;
    cmd = '0;
    param_mem_serial_in = ~busy;
  end

  always @(posedge param_mem_serial_clock)
  begin
    if (param_mem_select)
    begin
      cnt++;
      if (cnt <= 9)
        cmd = {cmd[7:0], param_mem_serial_out};
      else if (cnt <= 25)
        data = {data[14:0], param_mem_serial_out};
      if (cnt == 9)
      begin
        // anything else, erase included, is counted as a fault
        if (!(cmd inside {`SPE_CMD_READ_W0, `SPE_CMD_READ_W1, `SPE_CMD_EWEN,
                          `SPE_CMD_WRITE_W0}))
          n_bad++;
        if (cmd == `SPE_CMD_EWEN)
          ewen = 1'b1;
      end
      if (cmd[8:6] == 3'b110 && cnt >= 9 && cnt <= 25)
        param_mem_serial_in = (cnt == 9) ? 1'b0 : mem[cmd[0]][25 - cnt];
    end
  end

  // programming starts when select drops after a full write frame
  always @(negedge param_mem_select)
  begin
    if (cnt == 25 && cmd[8:6] == 3'b101)
    begin
      if (ewen && cmd == `SPE_CMD_WRITE_W0)
      begin
        mem[0] = data;
        n_write++;
        busy = 1'b1;
      end
      else
        n_bad++;
      // disabled again so an enable is needed before every write
      ewen = 1'b0;
    end
    param_mem_serial_in = ~param_mem_serial_in;
  end

  always @(posedge busy)
  begin
    #(PROG_NS);
    busy = 1'b0;
    if (param_mem_select)
      param_mem_serial_in = 1'b1;
  end
endmodule

// ---- bench/tb_serial_param_eeprom_ctrl.sv ----
`timescale 1ns/10ps

`define CHK(name, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
  end

module tb_serial_param_eeprom_ctrl;
  import spe_pkg::*;
  // short counts keep the run near 100k cycles
  localparam int unsigned RD_CYC = 2000;
  localparam int unsigned WR_CYC = 1000;
  // the ready timeout runs from cycle start, so it must outlast both write frames
  localparam int unsigned TO_CYC = 40000;

  logic       clk_sys, reset_n;
  logic       serial_param_enable, eeprom_or_shifter_select, address_change_allowed;
  logic       read_req_set, write_req_set, telegram_ok;
  spe_addr_s  new_address;
  logic       read_req, write_req, write_accept, write_nack_rs, baud_detect_req;
  logic       params_valid;
  spe_param_s params;
  logic       param_mem_select, param_mem_serial_clock, param_mem_serial_out;
  logic       param_mem_serial_in;
  int         fails;
  int         num_checks;

  spe_ctrl #(.READ_CYCLE_CYC(RD_CYC), .WRITE_CYCLE_CYC(WR_CYC), .PROG_TIMEOUT_CYC(TO_CYC))
  uut
  (
    .clk_sys(clk_sys), .reset_n(reset_n), .serial_param_enable(serial_param_enable),
    .eeprom_or_shifter_select(eeprom_or_shifter_select),
    .address_change_allowed(address_change_allowed), .read_req_set(read_req_set),
    .write_req_set(write_req_set), .telegram_ok(telegram_ok), .new_address(new_address),
    .read_req(read_req), .write_req(write_req), .write_accept(write_accept),
    .write_nack_rs(write_nack_rs), .baud_detect_req(baud_detect_req),
    .params_valid(params_valid), .params(params), .param_mem_select(param_mem_select),
    .param_mem_serial_clock(param_mem_serial_clock),
    .param_mem_serial_out(param_mem_serial_out), .param_mem_serial_in(param_mem_serial_in)
  );

  spe_eeprom_model mdl
  (
    .param_mem_select(param_mem_select), .param_mem_serial_clock(param_mem_serial_clock),
    .param_mem_serial_out(param_mem_serial_out), .param_mem_serial_in(param_mem_serial_in)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // waits for a cycle to start, then for both flags to fall
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (read_req !== 1'b1 && write_req !== 1'b1 && n < 10)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    n = 0;
    while ((read_req !== 1'b0 || write_req !== 1'b0) && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("cycle end", 1'b1, n < lim)
  endtask

  task automatic pulse_write(input spe_addr_s a, input logic ok, input logic acc,
                             input logic nack);
    @(posedge clk_sys);
    write_req_set <= 1'b1;
    telegram_ok   <= ok;
    new_address   <= a;
    @(posedge clk_sys);
    write_req_set <= 1'b0;
    #1;
    `CHK("write_accept", acc, write_accept)
    `CHK("write_nack_rs", nack, write_nack_rs)
    @(posedge clk_sys);
    #1;
    `CHK("baud_detect_req", acc, baud_detect_req)
  endtask

  task automatic pulse_read(input logic exp);
    @(posedge clk_sys);
    read_req_set <= 1'b1;
    @(posedge clk_sys);
    read_req_set <= 1'b0;
    #1;
    `CHK("read_req", exp, read_req)
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    fails = 0;
    num_checks = 0;
    reset_n = 1'b0;
    serial_param_enable = 1'b1;
    eeprom_or_shifter_select = 1'b1;
    address_change_allowed = 1'b0;
    read_req_set = 1'b0;
    write_req_set = 1'b0;
    telegram_ok = 1'b0;
    new_address = '0;
    mdl.mem[0] = 16'h0085;
    mdl.mem[1] = 16'h1234;
    repeat (7) @(posedge clk_sys);
    #1;
    `CHK("pins in reset", 3'h0, {param_mem_select, param_mem_serial_clock, param_mem_serial_out})
    @(posedge clk_sys);
    reset_n <= 1'b1;
    wait_done(30000);
    `CHK("boot params", {1'b1, 7'h05, 16'h1234}, params)
    `CHK("params_valid", 1'b1, params_valid)
    `CHK("no write", 1'b0, write_req)
    $display("test boot read done");

    pulse_write('{lock: 1'b1, addr: 7'h22}, 1'b0, 1'b0, 1'b0);
    pulse_write('{lock: 1'b1, addr: 7'h22}, 1'b1, 1'b1, 1'b0);
    wait_done(30000);
    `CHK("programming done", 1'b0, mdl.busy)
    `CHK("word 0", 16'h00A2, mdl.mem[0])
    `CHK("word 1", 16'h1234, mdl.mem[1])
    `CHK("writes", 1, mdl.n_write)
    `CHK("params", {1'b1, 7'h22, 16'h1234}, params)
    $display("test write done");

    pulse_write('{lock: 1'b0, addr: 7'h33}, 1'b1, 1'b0, 1'b0);
    @(posedge clk_sys);
    address_change_allowed <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pulse_write('{lock: 1'b1, addr: 7'h7F}, 1'b1, 1'b1, 1'b0);
    wait_done(30000);
    `CHK("aca word 0", 16'h00FF, mdl.mem[0])
    `CHK("aca params", {1'b1, 7'h7F, 16'h1234}, params)
    `CHK("aca programming done", 1'b0, mdl.busy)
    $display("test locked refusal done");

    pulse_read(1'b1);
    wait_done(60000);
    `CHK("default word 0", 16'h007E, mdl.mem[0])
    `CHK("default params", {1'b0, 7'h7E, 16'h1234}, params)
    `CHK("default programming done", 1'b0, mdl.busy)
    `CHK("writes", 3, mdl.n_write)
    `CHK("bad commands", 0, mdl.n_bad)
    $display("test default address done");

    eeprom_or_shifter_select <= 1'b0;
    repeat (4) @(posedge clk_sys);
    pulse_write('{lock: 1'b0, addr: 7'h10}, 1'b1, 1'b0, 1'b1);
    pulse_read(1'b0);
    `CHK("pins idle", 3'h0, {param_mem_select, param_mem_serial_clock, param_mem_serial_out})
    @(posedge clk_sys);
    serial_param_enable <= 1'b0;
    eeprom_or_shifter_select <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pulse_write('{lock: 1'b0, addr: 7'h10}, 1'b1, 1'b0, 1'b1);
    pulse_read(1'b0);
    $display("test no memory done");
    give_verdict;
  end

  // whole run is about 107k cycles
  initial
  begin
    repeat (150000) @(posedge clk_sys);
    fails++;
    give_verdict;
  end
endmodule
